/* File: verilog/runtime_bank_defs.vh */
// Offsets, reset values and field positions of the runtime register bank
`ifndef RUNTIME_BANK_DEFS_VH
`define RUNTIME_BANK_DEFS_VH

`define ADDR_W 7
`define DATA_W 8

`define OFS_PIN13_CONTROL 7'h26
`define OFS_PIN14_CONTROL 7'h27
`define OFS_PIN15_CONTROL 7'h28
`define OFS_PIN16_CONTROL 7'h29
`define OFS_PIN17_CONTROL 7'h2a
`define OFS_PIN20_CONTROL 7'h2b
`define OFS_PIN21_CONTROL 7'h2c
`define OFS_PIN22_CONTROL 7'h2d
`define OFS_RESERVED_2E 7'h2e
`define OFS_PIN24_CONTROL 7'h2f
`define OFS_PIN25_CONTROL 7'h30
`define OFS_PIN26_CONTROL 7'h31
`define OFS_PIN27_CONTROL 7'h32
`define OFS_PIN30_CONTROL 7'h33
`define OFS_PIN31_CONTROL 7'h34
`define OFS_PIN32_CONTROL 7'h35
`define OFS_PIN33_CONTROL 7'h36
`define OFS_PIN34_CONTROL 7'h37
`define OFS_PIN35_CONTROL 7'h38
`define OFS_PIN36_CONTROL 7'h39
`define OFS_PIN37_CONTROL 7'h3a
`define OFS_PIN40_CONTROL 7'h3b
`define OFS_PIN41_CONTROL 7'h3c
`define OFS_PIN42_CONTROL 7'h3d
`define OFS_PIN43_CONTROL 7'h3e
`define OFS_PIN50_CONTROL 7'h3f
`define OFS_PIN51_CONTROL 7'h40
`define OFS_PIN52_CONTROL 7'h41
`define OFS_PIN53_CONTROL 7'h42
`define OFS_PIN54_CONTROL 7'h43
`define OFS_PIN55_CONTROL 7'h44
`define OFS_PIN56_CONTROL 7'h45
`define OFS_PIN57_CONTROL 7'h46
`define OFS_PIN60_CONTROL 7'h47
`define OFS_PIN61_CONTROL 7'h48
`define OFS_IO_GROUP1_DATA 7'h4b
`define OFS_IO_GROUP2_DATA 7'h4c
`define OFS_IO_GROUP3_DATA 7'h4d
`define OFS_IO_GROUP4_DATA 7'h4e
`define OFS_IO_GROUP5_DATA 7'h4f
`define OFS_IO_GROUP6_DATA 7'h50
`define OFS_FAN_ONE_OUTPUT 7'h56
`define OFS_FAN_TWO_OUTPUT 7'h57
`define OFS_FAN_CONTROL 7'h58
`define OFS_FAN_ONE_TACH_COUNT 7'h59
`define OFS_FAN_TWO_TACH_COUNT 7'h5a
`define OFS_FAN_ONE_TACH_PRELOAD 7'h5b
`define OFS_FAN_TWO_TACH_PRELOAD 7'h5c
`define OFS_INDICATOR_ONE_CONTROL 7'h5d
`define OFS_INDICATOR_TWO_CONTROL 7'h5e
`define OFS_KEY_SCAN_CODE 7'h5f

`define RST_PIN_CONTROL 8'h01
`define RST_PIN34_CONTROL 8'h05
`define RST_PIN35_CONTROL 8'h04
`define RST_PIN53_CONTROL 8'h00
`define RST_MAIN_PIN3233 8'h00
`define RST_IO_GROUP 8'h00
`define RST_FAN_OUTPUT 8'h00
`define RST_FAN_CONTROL 8'h50
`define RST_TACH 8'h00
`define RST_INDICATOR 8'h00
`define RST_ZERO 8'h00

// Pin control and group data field positions
`define PIN_DIR_BIT 0
`define PIN43_FUNC_HI 3
`define PIN43_FUNC_LO 2
`define PIN43_FUNC_LOCK 2'b01
`define GROUP5_CLR_BIT 3

`endif

/* File: verilog/fan_tach_counter.v */
// Fan tachometer pulse counter with software preload
`timescale 1ns/100ps
module fan_tach_counter #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Tachometer pin
  input wire tach_pin,
  // Preload from register bank
  input wire preload_load,
  input wire [WIDTH-1:0] preload_value,
  // Count seen by software
  output reg [WIDTH-1:0] count
);

  reg tach_meta;
  reg tach_sync;
  reg tach_prev;

  always @(posedge sys_clk) begin
    if (rst) begin
      tach_meta <= 1'b0;
      tach_sync <= 1'b0;
      tach_prev <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else begin
      tach_meta <= tach_pin;
      tach_sync <= tach_meta;
      tach_prev <= tach_sync;
      if (preload_load) begin
        count <= preload_value;
      end else if (tach_sync && !tach_prev && count != {WIDTH{1'b1}}) begin
        // Saturate so a stalled read never sees a wrapped small value
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: verilog/runtime_gpio_fan_register_bank.v */
// Runtime register bank: pin control, group data, fan and indicator registers
`timescale 1ns/100ps
`include "runtime_bank_defs.vh"
module runtime_gpio_fan_register_bank (
  // Clock and standby-supply power-on reset
  input wire sys_clk,
  input wire rst,
  // Other reset sources, synchronous levels
  input wire hard_reset,
  input wire main_por,
  // Register port at the runtime I/O base
  input wire [`ADDR_W-1:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [`DATA_W-1:0] reg_wdata,
  output reg [`DATA_W-1:0] reg_rdata,
  output reg reg_rvalid,
  // Pins
  input wire pin43_level,
  input wire fan_one_tach_pin,
  input wire fan_two_tach_pin,
  // Parallel port status path
  input wire parport_activate,
  input wire parport_irq_in,
  output reg parport_irq_status,
  // Lock for the device-disable register
  output reg device_disable_locked,
  // Power-on set pulses for wake and management status
  output reg [1:0] wake_status_bank_four_set,
  output reg [1:0] mgmt_irq_status_bank_four_set,
  output reg wake_status_bank_five_set,
  // Fan and indicator outputs
  output reg [`DATA_W-1:0] fan_one_duty,
  output reg [`DATA_W-1:0] fan_two_duty,
  output reg [`DATA_W-1:0] fan_mode,
  output reg [`DATA_W-1:0] indicator_one,
  output reg [`DATA_W-1:0] indicator_two
);

  reg [`DATA_W-1:0] bank [0:127];
  reg pin43_meta;
  reg pin43_sync;
  reg main_por_prev;
  wire [`DATA_W-1:0] fan_one_count;
  wire [`DATA_W-1:0] fan_two_count;
  wire [1:0] tach_pins;
  wire [1:0] preload_hit;
  wire [2*`DATA_W-1:0] tach_counts;
  wire write_hit;
  wire por_edge;
  integer i;
  genvar ch;

  // Standby-supply defaults of every mapped register
  function [`DATA_W-1:0] reset_value;
    input [`ADDR_W-1:0] ofs;
    begin
      if (ofs >= `OFS_PIN13_CONTROL && ofs <= `OFS_PIN22_CONTROL) begin
        reset_value = `RST_PIN_CONTROL;
      end else if (ofs >= `OFS_PIN24_CONTROL &&
                   ofs <= `OFS_PIN61_CONTROL) begin
        case (ofs)
          `OFS_PIN34_CONTROL: reset_value = `RST_PIN34_CONTROL;
          `OFS_PIN35_CONTROL: reset_value = `RST_PIN35_CONTROL;
          `OFS_PIN53_CONTROL: reset_value = `RST_PIN53_CONTROL;
          default: reset_value = `RST_PIN_CONTROL;
        endcase
      end else if (ofs == `OFS_FAN_CONTROL) begin
        reset_value = `RST_FAN_CONTROL;
      end else begin
        // Group data, fan outputs, preload and indicators all start at zero
        reset_value = `RST_ZERO;
      end
    end
  endfunction

  // Offsets that hold storage software may write
  function writable;
    input [`ADDR_W-1:0] ofs;
    begin
      if (ofs >= `OFS_PIN13_CONTROL && ofs <= `OFS_PIN22_CONTROL) begin
        writable = 1'b1;
      end else if (ofs >= `OFS_PIN24_CONTROL &&
                   ofs <= `OFS_PIN61_CONTROL) begin
        writable = 1'b1;
      end else if (ofs >= `OFS_IO_GROUP1_DATA &&
                   ofs <= `OFS_IO_GROUP6_DATA) begin
        writable = 1'b1;
      end else if (ofs >= `OFS_FAN_ONE_OUTPUT &&
                   ofs <= `OFS_FAN_CONTROL) begin
        writable = 1'b1;
      end else if (ofs >= `OFS_FAN_ONE_TACH_PRELOAD &&
                   ofs <= `OFS_KEY_SCAN_CODE) begin
        writable = 1'b1;
      end else begin
        // 0x2e, tach counts and every other reserved hole
        writable = 1'b0;
      end
    end
  endfunction

  // Preloads must not slip through while a reset holds the bank
  assign write_hit = reg_write && !hard_reset && !main_por &&
                     writable(reg_addr);
  assign por_edge = main_por && !main_por_prev;
  assign tach_pins = {fan_two_tach_pin, fan_one_tach_pin};
  assign preload_hit = {write_hit && reg_addr == `OFS_FAN_TWO_TACH_PRELOAD,
                        write_hit && reg_addr == `OFS_FAN_ONE_TACH_PRELOAD};
  assign fan_one_count = tach_counts[`DATA_W-1:0];
  assign fan_two_count = tach_counts[2*`DATA_W-1:`DATA_W];

  // Register storage and per-source resets
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 128; i = i + 1) begin
        bank[i] <= reset_value(i[`ADDR_W-1:0]);
      end
    end else if (hard_reset || main_por) begin
      bank[`OFS_PIN32_CONTROL] <= `RST_MAIN_PIN3233;
      bank[`OFS_PIN33_CONTROL] <= `RST_MAIN_PIN3233;
      bank[`OFS_PIN35_CONTROL] <= `RST_PIN35_CONTROL;
      bank[`OFS_PIN53_CONTROL] <= `RST_PIN53_CONTROL;
      bank[`OFS_PIN43_CONTROL][`PIN43_FUNC_HI:`PIN43_FUNC_LO] <=
        2'b00;
      bank[`OFS_IO_GROUP3_DATA][`PIN43_FUNC_HI:`PIN43_FUNC_LO] <=
        2'b00;
      bank[`OFS_IO_GROUP5_DATA][`GROUP5_CLR_BIT] <= 1'b0;
    end else if (write_hit) begin
      // No soft reset input: a soft reset leaves this bank alone
      bank[reg_addr] <= reg_wdata;
    end
  end

  // Read port, one cycle of latency
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (!reg_read) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == `OFS_FAN_ONE_TACH_COUNT) begin
        reg_rdata <= fan_one_count;
      end else if (reg_addr == `OFS_FAN_TWO_TACH_COUNT) begin
        reg_rdata <= fan_two_count;
      end else if (writable(reg_addr)) begin
        reg_rdata <= bank[reg_addr];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Pin synchroniser, lock and parallel port status
  always @(posedge sys_clk) begin
    if (rst) begin
      pin43_meta <= 1'b0;
      pin43_sync <= 1'b0;
      device_disable_locked <= 1'b0;
      parport_irq_status <= 1'b1;
    end else begin
      pin43_meta <= pin43_level;
      pin43_sync <= pin43_meta;
      device_disable_locked <=
        (bank[`OFS_PIN43_CONTROL][`PIN43_FUNC_HI:`PIN43_FUNC_LO] ==
         `PIN43_FUNC_LOCK) && pin43_sync;
      parport_irq_status <= parport_activate ? parport_irq_in
                                             : 1'b1;
    end
  end

  // Main-supply power-on set pulses; direction sampled before it clears
  always @(posedge sys_clk) begin
    if (rst) begin
      main_por_prev <= 1'b0;
      wake_status_bank_four_set <= 2'b00;
      mgmt_irq_status_bank_four_set <= 2'b00;
      wake_status_bank_five_set <= 1'b0;
    end else begin
      main_por_prev <= main_por;
      wake_status_bank_four_set <= {
        por_edge && bank[`OFS_PIN33_CONTROL][`PIN_DIR_BIT],
        por_edge && bank[`OFS_PIN32_CONTROL][`PIN_DIR_BIT]};
      mgmt_irq_status_bank_four_set <= {
        por_edge && bank[`OFS_PIN33_CONTROL][`PIN_DIR_BIT],
        por_edge && bank[`OFS_PIN32_CONTROL][`PIN_DIR_BIT]};
      wake_status_bank_five_set <=
        por_edge && bank[`OFS_PIN53_CONTROL][`PIN_DIR_BIT];
    end
  end

  // Output copies of the fan and indicator registers
  always @(posedge sys_clk) begin
    if (rst) begin
      fan_one_duty <= `RST_FAN_OUTPUT;
      fan_two_duty <= `RST_FAN_OUTPUT;
      fan_mode <= `RST_FAN_CONTROL;
      indicator_one <= `RST_INDICATOR;
      indicator_two <= `RST_INDICATOR;
    end else begin
      fan_one_duty <= bank[`OFS_FAN_ONE_OUTPUT];
      fan_two_duty <= bank[`OFS_FAN_TWO_OUTPUT];
      fan_mode <= bank[`OFS_FAN_CONTROL];
      indicator_one <= bank[`OFS_INDICATOR_ONE_CONTROL];
      indicator_two <= bank[`OFS_INDICATOR_TWO_CONTROL];
    end
  end

  // One counter per fan, each with its own preload strobe
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_tach
      fan_tach_counter #(
        .WIDTH(`DATA_W)
      ) u_fan_tach_counter (
        .sys_clk(sys_clk),
        .rst(rst),
        .tach_pin(tach_pins[ch]),
        .preload_load(preload_hit[ch]),
        .preload_value(reg_wdata),
        .count(tach_counts[ch*`DATA_W +: `DATA_W])
      );
    end
  endgenerate

endmodule

/* File: dv/runtime_bank_chk.sv */
// Concurrent checks on the runtime register bank ports
`timescale 1ns/100ps
`include "runtime_bank_defs.vh"
module runtime_bank_chk (
  // Clock, resets and register port
  input wire sys_clk,
  input wire rst,
  input wire hard_reset,
  input wire main_por,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire reg_read,
  input wire [`DATA_W-1:0] reg_rdata,
  input wire reg_rvalid,
  // Status paths
  input wire pin43_level,
  input wire parport_activate,
  input wire parport_irq_in,
  input wire parport_irq_status,
  input wire device_disable_locked,
  input wire [1:0] wake_status_bank_four_set,
  input wire [1:0] mgmt_irq_status_bank_four_set,
  input wire wake_status_bank_five_set
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_hole_reads_zero: assert property (
    reg_read && (reg_addr == 7'h2e || reg_addr >= 7'h60 ||
    reg_addr == 7'h49 || reg_addr == 7'h4a ||
    (reg_addr >= 7'h51 && reg_addr <= 7'h55)) |=> reg_rdata == 8'h00)
    else $error("reserved offset read not zero");
  a_idle_read_quiet: assert property (
    !reg_read |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data without a read");
  a_clear_field: assert property (
    (hard_reset || main_por) ##1 (reg_read &&
    (reg_addr == 7'h3e || reg_addr == 7'h4d)) |=> reg_rdata[3:2] == 2'b00)
    else $error("field 3:2 survived reset");
  a_clear_bit_three: assert property (
    (hard_reset || main_por) ##1 (reg_read && reg_addr == 7'h4f) |=>
    !reg_rdata[3])
    else $error("group five bit 3 survived reset");
  a_irq_idle_one: assert property (
    !parport_activate |=> parport_irq_status)
    else $error("parallel irq not 1 while inactive");
  a_irq_follows: assert property (
    parport_activate |=> parport_irq_status == $past(parport_irq_in))
    else $error("parallel irq does not follow source");
  a_pulse_cause: assert property (
    (|wake_status_bank_four_set || wake_status_bank_five_set) |->
    $past(main_por) && !$past(main_por, 2))
    else $error("wake pulse without main supply reset edge");
  a_pulse_pairing: assert property (
    wake_status_bank_four_set == mgmt_irq_status_bank_four_set)
    else $error("wake and mgmt pulses differ");
  a_lock_pin: assert property (
    device_disable_locked |-> $past(pin43_level, 3))
    else $error("lock set with pin low");
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the runtime register bank
`timescale 1ns/100ps
module tb;
  logic sys_clk = 0, rst = 1, hard_reset = 0, main_por = 0, reg_write = 0;
  logic reg_read = 0, pin43_level = 0, parport_activate = 0;
  logic fan_one_tach_pin = 0, fan_two_tach_pin = 0, parport_irq_in = 0;
  logic [6:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, fan_one_duty, fan_two_duty;
  logic [7:0] fan_mode, indicator_one, indicator_two, mem [128];
  logic reg_rvalid, parport_irq_status, device_disable_locked;
  logic wake_status_bank_five_set, w5;
  logic [1:0] m4;
  logic [1:0] wake_status_bank_four_set, mgmt_irq_status_bank_four_set, w4;
  int miscompares = 0, n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  runtime_gpio_fan_register_bank u_runtime_gpio_fan_register_bank (.*);
  function automatic logic [7:0] rst_val(int a);
    if (a == 'h37) return 8'h05;
    if (a == 'h38) return 8'h04;
    if (a == 'h42 || a == 'h2e) return 8'h00;
    if (a >= 'h26 && a <= 'h48) return 8'h01;
    return (a == 'h58) ? 8'h50 : 8'h00;
  endfunction
  function automatic bit wable(int a);
    return (a >= 'h26 && a <= 'h48 && a != 'h2e) || (a >= 'h4b && a <= 'h50)
      || (a >= 'h56 && a <= 'h58) || (a >= 'h5b && a <= 'h5f);
  endfunction
  task chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(int a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a[6:0];
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge sys_clk);
    reg_write <= 0;
    if (wable(a)) mem[a] = d;
    // Preload write also loads the tach count
    if (a == 'h5b || a == 'h5c) mem[a - 2] = d;
  endtask
  task rd(int a);
    @(posedge sys_clk);
    reg_addr <= a[6:0];
    reg_read <= 1;
    @(posedge sys_clk);
    reg_read <= 0;
    #1;
    chk("rvalid", 1, reg_rvalid);
    chk("rdata", mem[a], reg_rdata);
  endtask
  task rdall;
    for (int a = 'h26; a < 'h80; a++) rd(a);
  endtask
  initial begin
    void'($urandom(32'h22853456));
    for (int a = 0; a < 128; a++) mem[a] = rst_val(a);
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    chk("fan_mode", 8'h50, fan_mode);
    rdall();
    for (int a = 'h26; a < 'h80; a++) wr(a, $urandom);
    rdall();
    chk("fan_one", mem['h56], fan_one_duty);
    chk("fan_two", mem['h57], fan_two_duty);
    chk("fan_mode", mem['h58], fan_mode);
    chk("ind_one", mem['h5d], indicator_one);
    chk("ind_two", mem['h5e], indicator_two);
    // Second pulse checks saturation at the top
    wr('h5b, 8'hfe);
    wr('h5c, 8'h10);
    repeat (2) begin
      fan_one_tach_pin <= 1;
      fan_two_tach_pin <= 1;
      repeat (4) @(posedge sys_clk);
      fan_one_tach_pin <= 0;
      fan_two_tach_pin <= 0;
      repeat (10) @(posedge sys_clk);
    end
    mem['h59] = 8'hff;
    mem['h5a] = 8'h12;
    rd('h59);
    rd('h5a);
    for (int k = 0; k < 2; k++) begin
      wr('h35, 8'h41);
      wr('h36, 8'h40);
      wr('h42, 8'h03);
      wr('h3e, 8'hff);
      wr('h4d, 8'hff);
      wr('h4f, 8'hff);
      wr('h38, 8'h00);
      w4 = 0;
      w5 = 0;
      m4 = 0;
      @(posedge sys_clk);
      // Wake pulses are expected from a main-supply reset only
      if (k) main_por <= 1;
      else hard_reset <= 1;
      repeat (4) begin
        @(posedge sys_clk);
        #1;
        w4 |= wake_status_bank_four_set;
        w5 |= wake_status_bank_five_set;
        m4 |= mgmt_irq_status_bank_four_set;
      end
      chk("wake4", k ? 8'h01 : 8'h00, w4);
      chk("mgmt4", k ? 8'h01 : 8'h00, m4);
      chk("wake5", k, w5);
      mem['h35] = 0;
      mem['h36] = 0;
      mem['h42] = 0;
      mem['h38] = 8'h04;
      mem['h3e] = 8'hf3;
      mem['h4d] = 8'hf3;
      mem['h4f] = 8'hf7;
      // Read in the cycle right behind the reset
      @(posedge sys_clk);
      main_por <= 0;
      hard_reset <= 0;
      reg_addr <= k ? 7'h4f : 7'h3e;
      reg_read <= 1;
      @(posedge sys_clk);
      reg_read <= 0;
      #1;
      if (k) chk("grp5", mem['h4f], reg_rdata);
      else chk("pin43", mem['h3e], reg_rdata);
      rdall();
    end
    wr('h3e, 8'h05);
    pin43_level <= 1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("locked", 1, device_disable_locked);
    wr('h3e, 8'h09);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("locked", 0, device_disable_locked);
    repeat (40) begin
      @(posedge sys_clk);
      parport_activate <= $urandom;
      parport_irq_in <= $urandom;
      @(posedge sys_clk);
      #1;
      chk("irq", !parport_activate | parport_irq_in,
          parport_irq_status);
    end
    stop_test();
  end
endmodule
bind runtime_gpio_fan_register_bank runtime_bank_chk u_runtime_bank_chk (.*);
